// ---- src/swsig_pkg.sv ----
// Shared constants for the single-wire slot master.
package swsig_pkg;

   // System clock and the microsecond tick that all slot timing is counted in.
   localparam int unsigned CLOCK_MHZ = 100;
   localparam int unsigned TICK_US = 1;
   localparam int unsigned TICK_CYCLES = CLOCK_MHZ * TICK_US;

   // Fixed limits of the line: the write-one low limit and the idle-low reset hazard.
   localparam int unsigned WRITE_ONE_LOW_LIMIT_US = 15;
   localparam int unsigned IDLE_LOW_LIMIT_US = 120;

   // Default slot timing in microseconds, overridable per instance.
   localparam int unsigned RESET_LOW_DURATION_US = 480;
   localparam int unsigned RESET_FALL_US = 0;
   localparam int unsigned RESET_HIGH_US = 480;
   localparam int unsigned PRESENCE_SAMPLE_INSTANT_US = 70;
   localparam int unsigned SLOT_DURATION_US = 65;
   localparam int unsigned WRITE_ZERO_LOW_FLOOR_US = 60;
   localparam int unsigned WRITE_ONE_LOW_US = 6;
   localparam int unsigned READ_INITIATE_LOW_TIME_US = 6;
   localparam int unsigned READ_SAMPLE_US = 13;
   localparam int unsigned SLOT_RECOVERY_TIME_US = 5;

   // Widths and the depth of the read-data buffer.
   localparam int unsigned TIMER_W = 10;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FIFO_DEPTH = 8;

   // Commands accepted from the user side.
   typedef enum logic [1:0] {
      SWSIG_CMD_RESET,
      SWSIG_CMD_WRITE,
      SWSIG_CMD_READ
   } swsig_cmd_e;

endpackage : swsig_pkg

// ---- src/swsig_tick.sv ----
`timescale 1ns/1ps
// Divider giving one-cycle tick pulses; a clear realigns the phase.
module swsig_tick import swsig_pkg::*; #(
   parameter int unsigned DIVIDE = TICK_CYCLES
) (
   input wire logic i_clock,     // System clock.
   input wire logic i_sys_rst,   // Synchronous reset, active high.
   input wire logic i_clear,     // Restart the tick period.
   output logic o_tick           // One-cycle tick pulse.
);

   localparam int unsigned CW = $clog2(DIVIDE + 1);

   logic [CW-1:0] div_ff;
   wire wrap = (div_ff == CW'(DIVIDE - 1));

   // Restarting on clear makes every interval start a whole tick before its first count.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || i_clear || wrap) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end

   // The tick leaves from a flip-flop.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || i_clear) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= wrap;
      end
   end

   if (DIVIDE < 2) begin : g_chk
      $error("swsig_tick needs DIVIDE of at least 2.");
   end

endmodule : swsig_tick

// ---- src/swsig_fifo.sv ----
`timescale 1ns/1ps
// Small synchronous FIFO with valid and ready on both sides.
module swsig_fifo import swsig_pkg::*; #(
   parameter int unsigned WIDTH = DATA_W,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input wire logic i_clock,              // System clock.
   input wire logic i_sys_rst,            // Synchronous reset, active high.
   input wire logic i_in_valid,           // Write side offers a word.
   output logic o_in_ready,               // Room for a word.
   input wire logic [WIDTH-1:0] i_in_data, // Word to store.
   output logic o_out_valid,              // A word is available.
   input wire logic i_out_ready,          // Reader takes the word.
   output logic [WIDTH-1:0] o_out_data    // Oldest word.
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ff;
   logic [AW:0] rd_ff;

   // Pointers carry one extra bit so that full and empty are told apart.
   wire empty = (wr_ff == rd_ff);
   wire full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
   wire push = i_in_valid && !full;
   wire pop = !empty && i_out_ready;

   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_ff[AW-1:0]];

   // Storage array has no reset; only the pointers need one.
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= i_in_data;
      end
   end

   // Pointer update.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("swsig_fifo needs a power-of-two DEPTH of at least 2.");
   end

endmodule : swsig_fifo

// ---- src/swsig_master.sv ----
`timescale 1ns/1ps
// How it works
// - Only reset, write-zero, write-one, read slots.
// - Master starts everything except the presence pulse.
// - Reset low lengthened by the fall time.
// - Master releases line after reset low.
// - Sample presence at the sample instant.
// - Data moves one bit per slot.
// - Writes to slave, reads from slave.
// - Write-one released before the low limit.
// - Write-zero held low past the floor.
// - Read slot: short low, then release.
// - Read bit sampled inside the window.
// - Short read low, sample late in window.
// - Wait full slot before the next.
// - Line idles high; long low resets slaves.
// - Nothing new before reset high time ends.
module swsig_master import swsig_pkg::*; #(
   parameter int unsigned DIVIDE = TICK_CYCLES,
   parameter int unsigned RESET_LOW_US = RESET_LOW_DURATION_US,
   parameter int unsigned FALL_US = RESET_FALL_US,
   parameter int unsigned RESET_HI_US = RESET_HIGH_US,
   parameter int unsigned PRESENCE_US = PRESENCE_SAMPLE_INSTANT_US,
   parameter int unsigned SLOT_US = SLOT_DURATION_US,
   parameter int unsigned ZERO_LOW_US = WRITE_ZERO_LOW_FLOOR_US,
   parameter int unsigned ONE_LOW_US = WRITE_ONE_LOW_US,
   parameter int unsigned READ_LOW_US = READ_INITIATE_LOW_TIME_US,
   parameter int unsigned SAMPLE_US = READ_SAMPLE_US,
   parameter int unsigned RECOVERY_US = SLOT_RECOVERY_TIME_US,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input wire logic i_clock,                 // System clock, 100 MHz.
   input wire logic i_sys_rst,               // Synchronous reset, active high.
   input wire logic i_cmd_valid,             // Command offered.
   input wire swsig_cmd_e i_cmd_kind,        // Reset, write byte or read byte.
   input wire logic [DATA_W-1:0] i_cmd_data, // Byte to write, LSB first.
   output logic o_cmd_ready,                 // Command taken when valid is high.
   output logic o_rd_valid,                  // Read byte available.
   output logic [DATA_W-1:0] o_rd_data,      // Oldest read byte.
   input wire logic i_rd_ready,              // Reader takes the byte.
   output logic o_presence,                  // A slave answered the last reset.
   output logic o_presence_valid,            // Pulse when presence is sampled.
   output logic o_busy,                      // A sequence is in progress.
   input wire logic i_line,                  // Level of the shared line.
   output logic o_line_out,                  // Driven level, always low.
   output logic o_line_oe_n                  // Low while pulling the line down.
);

   typedef enum logic [2:0] {
      SWSIG_IDLE,
      SWSIG_RST_LOW,
      SWSIG_RST_HIGH,
      SWSIG_SLOT,
      SWSIG_RECOV,
      SWSIG_PUSH
   } swsig_state_e;

   // Interval ends in ticks; the reset low includes any slow falling edge.
   localparam logic [TIMER_W-1:0] T_RST = TIMER_W'(RESET_LOW_US + FALL_US);
   localparam logic [TIMER_W-1:0] T_RSTH = TIMER_W'(RESET_HI_US);
   localparam logic [TIMER_W-1:0] T_MSP = TIMER_W'(PRESENCE_US);
   localparam logic [TIMER_W-1:0] T_SLOT = TIMER_W'(SLOT_US);
   localparam logic [TIMER_W-1:0] T_W0 = TIMER_W'(ZERO_LOW_US);
   localparam logic [TIMER_W-1:0] T_W1 = TIMER_W'(ONE_LOW_US);
   localparam logic [TIMER_W-1:0] T_RL = TIMER_W'(READ_LOW_US);
   localparam logic [TIMER_W-1:0] T_SMP = TIMER_W'(SAMPLE_US);
   localparam logic [TIMER_W-1:0] T_REC = TIMER_W'(RECOVERY_US);

   swsig_state_e state_ff;
   swsig_state_e nxt_state;
   logic [TIMER_W-1:0] cnt_ff;
   logic step_ff;
   logic [DATA_W-1:0] sh_ff;
   logic [2:0] bit_ff;
   logic rd_ff;
   logic drive_ff;
   logic presence_ff;
   logic presence_valid_ff;
   logic tick;
   logic fifo_in_ready;

   // Interval events fire once, in the first cycle that the count holds its value.
   wire at_rst = step_ff && (cnt_ff == T_RST);
   wire at_rsth = step_ff && (cnt_ff == T_RSTH);
   wire at_msp = step_ff && (cnt_ff == T_MSP);
   wire at_slot = step_ff && (cnt_ff == T_SLOT);
   wire at_smp = step_ff && (cnt_ff == T_SMP);
   wire at_rec = step_ff && (cnt_ff == T_REC);
   wire last_bit = (bit_ff == 3'h7);
   wire in_idle = (state_ff == SWSIG_IDLE);
   wire in_slot = (state_ff == SWSIG_SLOT);
   wire cmd_fire = i_cmd_valid && o_cmd_ready;
   wire clr = (nxt_state != state_ff);

   // Low length of the current slot: reads and ones are short, zeros long.
   wire [TIMER_W-1:0] low_len = rd_ff ? T_RL : (sh_ff[0] ? T_W1 : T_W0);
   wire drive_low = (state_ff == SWSIG_RST_LOW) || (in_slot && (cnt_ff < low_len));

   // A read is only accepted while the buffer has room for its byte.
   assign o_cmd_ready = in_idle && ((i_cmd_kind != SWSIG_CMD_READ) || fifo_in_ready);
   assign o_busy = !in_idle;
   assign o_line_out = 1'b0;
   assign o_line_oe_n = !drive_ff;
   assign o_presence = presence_ff;
   assign o_presence_valid = presence_valid_ff;

   swsig_tick #(
      .DIVIDE(DIVIDE)
   ) u_tick (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_clear(clr),
      .o_tick(tick)
   );

   swsig_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(state_ff == SWSIG_PUSH),
      .o_in_ready(fifo_in_ready),
      .i_in_data(sh_ff),
      .o_out_valid(o_rd_valid),
      .i_out_ready(i_rd_ready),
      .o_out_data(o_rd_data)
   );

   // Sequencer; every interval is measured from the state entry.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SWSIG_IDLE: begin
            if (cmd_fire) begin
               nxt_state = (i_cmd_kind == SWSIG_CMD_RESET) ? SWSIG_RST_LOW : SWSIG_SLOT;
            end
         end
         SWSIG_RST_LOW: begin
            if (at_rst) begin
               nxt_state = SWSIG_RST_HIGH;
            end
         end
         SWSIG_RST_HIGH: begin
            if (at_rsth) begin
               nxt_state = SWSIG_IDLE;
            end
         end
         SWSIG_SLOT: begin
            if (at_slot) begin
               nxt_state = SWSIG_RECOV;
            end
         end
         SWSIG_RECOV: begin
            if (at_rec) begin
               nxt_state = !last_bit ? SWSIG_SLOT : (rd_ff ? SWSIG_PUSH : SWSIG_IDLE);
            end
         end
         SWSIG_PUSH: begin
            if (fifo_in_ready) begin
               nxt_state = SWSIG_IDLE;
            end
         end
         default: begin
            nxt_state = SWSIG_IDLE;
         end
      endcase
   end

   // State and tick counter.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_ff <= SWSIG_IDLE;
         cnt_ff <= '0;
         step_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= clr ? '0 : (tick ? cnt_ff + 1'b1 : cnt_ff);
         step_ff <= tick && !clr;
      end
   end

   // Bit shifter: LSB first; a read shifts the sampled line in from the top.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sh_ff <= '0;
         bit_ff <= '0;
         rd_ff <= 1'b0;
      end else if (cmd_fire) begin
         sh_ff <= (i_cmd_kind == SWSIG_CMD_WRITE) ? i_cmd_data : '0;
         bit_ff <= '0;
         rd_ff <= (i_cmd_kind == SWSIG_CMD_READ);
      end else if (in_slot && rd_ff && at_smp) begin
         sh_ff <= {i_line, sh_ff[DATA_W-1:1]};
      end else if ((state_ff == SWSIG_RECOV) && at_rec) begin
         sh_ff <= rd_ff ? sh_ff : {1'b0, sh_ff[DATA_W-1:1]};
         bit_ff <= bit_ff + 1'b1;
      end
   end

   // A low line at the sample instant means some slave answered the reset.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         presence_ff <= 1'b0;
         presence_valid_ff <= 1'b0;
      end else begin
         presence_valid_ff <= (state_ff == SWSIG_RST_HIGH) && at_msp;
         if ((state_ff == SWSIG_RST_HIGH) && at_msp) begin
            presence_ff <= !i_line;
         end
      end
   end

   // Pin enable leaves a flip-flop so the line sees no decode glitches.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         drive_ff <= 1'b0;
      end else begin
         drive_ff <= drive_low;
      end
   end

   if (SAMPLE_US <= READ_LOW_US || SAMPLE_US >= SLOT_US || ZERO_LOW_US >= SLOT_US ||
       ONE_LOW_US >= WRITE_ONE_LOW_LIMIT_US || PRESENCE_US >= RESET_HI_US ||
       RESET_LOW_US + FALL_US >= (1 << TIMER_W) || RESET_HI_US >= (1 << TIMER_W) ||
       RECOVERY_US == 0 || READ_LOW_US == 0) begin : g_chk
      $error("swsig_master timing parameters are inconsistent.");
   end

   // Checking helpers: length of the current low drive in cycles.
   localparam int C_W1_LIMIT = WRITE_ONE_LOW_LIMIT_US * DIVIDE;
   localparam int C_W0 = ZERO_LOW_US * DIVIDE;
   localparam int C_RL = (READ_LOW_US + 1) * DIVIDE;
   localparam int C_RST = (RESET_LOW_US + FALL_US) * DIVIDE;
   localparam int C_RSTH = RESET_HI_US * DIVIDE;
   localparam int C_SLOT = SLOT_US * DIVIDE;
   logic [19:0] low_run_ff;
   logic [19:0] state_age_ff;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !drive_ff) begin
         low_run_ff <= '0;
      end else begin
         low_run_ff <= low_run_ff + 1'b1;
      end
   end

   // Checking helper: cycles spent in the present state, cleared on every change.
   // It may wrap during a long idle, which is harmless as only timed states read it.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || clr) begin
         state_age_ff <= '0;
      end else begin
         state_age_ff <= state_age_ff + 1'b1;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   sequence s_slot_accept;
      cmd_fire && (i_cmd_kind != SWSIG_CMD_RESET);
   endsequence
   sequence s_line_falls;
      ##[1:2] $fell(o_line_oe_n);
   endsequence
   sequence s_rsth_done;
      (state_ff == SWSIG_RST_HIGH) && (nxt_state != SWSIG_RST_HIGH);
   endsequence
   sequence s_slot_done;
      in_slot && (nxt_state != SWSIG_SLOT);
   endsequence

   a_slot_starts_low: assert property (s_slot_accept |-> s_line_falls)
      else $error("Accepted slot did not pull the line low.");
   a_idle_released: assert property (in_idle && $past(in_idle) |-> o_line_oe_n)
      else $error("Line driven while idle.");
   a_one_low_limit: assert property (in_slot && !rd_ff && sh_ff[0] |->
                                     low_run_ff < 20'(C_W1_LIMIT))
      else $error("Write-one low too long.");
   a_zero_low_floor: assert property (in_slot && !rd_ff && !sh_ff[0] &&
                                      $rose(o_line_oe_n) |->
                                      $past(low_run_ff) >= 20'(C_W0) - 20'h1)
      else $error("Write-zero released too early.");
   a_read_low_short: assert property (in_slot && rd_ff |-> low_run_ff <= 20'(C_RL))
      else $error("Read slot held low too long.");
   a_reset_low_len: assert property ($rose(o_line_oe_n) &&
                                     state_ff == SWSIG_RST_HIGH |->
                                     $past(low_run_ff) >= 20'(C_RST))
      else $error("Reset low shorter than required.");
   a_recovery_free: assert property (state_ff == SWSIG_RECOV |-> o_line_oe_n)
      else $error("Line driven during recovery.");
   a_presence_phase: assert property (o_presence_valid |-> state_ff == SWSIG_RST_HIGH)
      else $error("Presence sampled outside reset high phase.");
   a_busy_refuses: assert property (cmd_fire |=> o_busy && !o_cmd_ready)
      else $error("Command accepted while busy.");
   a_reset_high_len: assert property (s_rsth_done |-> state_age_ff >= 20'(C_RSTH))
      else $error("Reset high phase ended early.");
   a_slot_full_len: assert property (s_slot_done |-> state_age_ff >= 20'(C_SLOT))
      else $error("Slot ended before its full duration.");
   a_read_after_release: assert property (in_slot && rd_ff && at_smp |->
                                          o_line_oe_n && state_age_ff < 20'(C_SLOT))
      else $error("Read bit sampled outside the window.");

endmodule : swsig_master

// ---- sim/swsig_slave_model.sv ----
`timescale 1ns/1ps
// Behavioural slave on the shared line, timed in clock cycles, US cycles to a microsecond.
module swsig_slave_model #(
   parameter int unsigned US = 2
) (
   input wire logic i_clock,         // Bench clock.
   input wire logic i_line,          // Resolved line level.
   input wire logic i_present,       // Slave attached to the line.
   input wire logic i_slow,          // Answer presence late.
   input wire logic i_read,          // Return bits instead of taking them.
   input wire logic [7:0] i_tx_byte, // Byte returned, bit 0 first.
   output logic o_pull_n,            // Low while the slave pulls the line.
   output logic [7:0] o_rx_byte      // Written bits, the last one in bit 7.
);
   int low_cnt = 0;
   int slot_cnt = 0;
   int pres_cnt = 0;
   int bit_idx = 0;
   logic line_q = 1'b1;
   logic armed = 1'b0;
   logic pull = 1'b0;

   // An absent slave never touches the line, and a one is returned by leaving it alone.
   assign o_pull_n = !(pull && i_present);

   // Logic levels stand for the thresholds; every slot is timed from the falling edge.
   always @(posedge i_clock) begin
      line_q <= i_line;
      low_cnt = i_line ? 0 : low_cnt + 1;
      if (low_cnt == 400 * US) begin
         armed <= 1'b1;
         bit_idx = 0;
      end
      if (armed && i_line) begin
         armed <= 1'b0;
         pres_cnt = 1;
      end else if (pres_cnt != 0) begin
         pres_cnt++;
      end
      if (pres_cnt == (i_slow ? 60 : 30) * US) pull <= 1'b1;
      if (pres_cnt == (i_slow ? 180 : 150) * US) begin
         pull <= 1'b0;
         pres_cnt = 0;
      end
      if (line_q && !i_line && pres_cnt == 0 && !armed) begin
         slot_cnt = 1;
         if (i_read && !i_tx_byte[bit_idx % 8]) pull <= 1'b1;
      end else if (slot_cnt != 0) begin
         slot_cnt++;
      end
      // The write sample sits between the one limit and the zero floor.
      if (slot_cnt == 30 * US) begin
         if (!i_read) o_rx_byte <= {i_line, o_rx_byte[7:1]};
         pull <= 1'b0;
         slot_cnt = 0;
         bit_idx++;
      end
   end
endmodule : swsig_slave_model

// ---- sim/swsig_master_bench.sv ----
`timescale 1ns/1ps
// Self-checking bench: the master against a behavioural slave on a wired-AND line.
module swsig_master_bench import swsig_pkg::*;;
   localparam int US = 2;
   localparam int FALL = 4;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_cmd_valid = 1'b0;
   swsig_cmd_e i_cmd_kind = SWSIG_CMD_RESET;
   logic [DATA_W-1:0] i_cmd_data = 8'h00;
   logic i_rd_ready = 1'b0;
   logic o_cmd_ready, o_rd_valid, o_presence, o_presence_valid, o_busy, o_line_out, o_line_oe_n;
   logic [DATA_W-1:0] o_rd_data;
   logic present = 1'b1;
   logic slow = 1'b0;
   logic rd_mode = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] rx_byte;
   logic pull_n;
   wire line;
   int num_errors = 0;
   int checked = 0;
   int low_run = 0;
   int gap_run = 0;
   int lows[$];
   int gaps[$];

   // Released drivers leave the line to the pull-up.
   assign line = (o_line_oe_n ? 1'b1 : o_line_out) & pull_n;

   always #5 i_clock = ~i_clock;

   swsig_master #(.DIVIDE(US), .FALL_US(FALL)) DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind), .i_cmd_data(i_cmd_data),
      .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
      .i_rd_ready(i_rd_ready), .o_presence(o_presence), .o_presence_valid(o_presence_valid),
      .o_busy(o_busy), .i_line(line), .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n));

   swsig_slave_model #(.US(US)) slave (.i_clock(i_clock), .i_line(line), .i_present(present),
      .i_slow(slow), .i_read(rd_mode), .i_tx_byte(tx_byte), .o_pull_n(pull_n),
      .o_rx_byte(rx_byte));

   // Records every low pulse of the master and the spacing of its falling edges.
   always @(posedge i_clock) begin
      gap_run++;
      if (!o_line_oe_n) begin
         if (low_run == 0) begin
            gaps.push_back(gap_run);
            gap_run = 0;
         end
         low_run++;
      end else if (low_run != 0) begin
         lows.push_back(low_run);
         low_run = 0;
      end
   end

   task automatic complete_run();
      $display("Errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic fail(input string msg);
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
   endtask : fail

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) fail($sformatf("%s: got %h, expected %h", what, got, exp));
   endtask : check_val

   task automatic check_range(input int got, input int lo, input int hi, input string what);
      checked++;
      if (got < lo || got > hi) fail($sformatf("%s: %0d outside %0d..%0d", what, got, lo, hi));
   endtask : check_range

   task automatic step();
      @(posedge i_clock);
      #1;
   endtask : step

   // Ready is judged at the falling edge so that the taking edge is known exactly.
   task automatic issue(input swsig_cmd_e kind, input logic [7:0] data);
      int n;
      i_cmd_kind = kind;
      i_cmd_data = data;
      i_cmd_valid = 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge i_clock);
         if (o_cmd_ready === 1'b1) break;
      end
      if (n == 100) begin
         fail("command not taken");
         complete_run();
      end
      step();
      i_cmd_valid = 1'b0;
   endtask : issue

   task automatic wait_idle();
      int n;
      step();
      for (n = 0; n < 20000 && o_busy !== 1'b0; n++) step();
      if (n == 20000) begin
         fail("busy never dropped");
         complete_run();
      end
   endtask : wait_idle

   task automatic run_reset(input logic att, input logic late);
      int n;
      present = att;
      slow = late;
      lows.delete();
      issue(SWSIG_CMD_RESET, 8'h00);
      for (n = 0; n < 3000 && o_presence_valid !== 1'b1; n++) step();
      if (n == 3000) begin
         fail("presence never sampled");
         complete_run();
      end
      check_val({7'h0, o_presence}, {7'h0, att}, "presence");
      for (n = 0; n < 3000 && o_busy !== 1'b0; n++) step();
      if (n == 3000) begin
         fail("reset high never ended");
         complete_run();
      end
      n = n + 1;
      check_range(n, (RESET_HIGH_US - PRESENCE_SAMPLE_INSTANT_US) * US - 4,
         (RESET_HIGH_US - PRESENCE_SAMPLE_INSTANT_US) * US + 4, "reset high");
      check_range(lows[0], (RESET_LOW_DURATION_US + FALL) * US - 2,
         (RESET_LOW_DURATION_US + FALL) * US + 2, "reset low");
      check_val({7'h0, o_line_oe_n}, 8'h01, "idle level");
   endtask : run_reset

   // Each of the two timed phases of a slot may end up to two cycles late, so the
   // spacing of falling edges runs from the nominal sum to four cycles above it.
   task automatic run_write(input logic [7:0] data);
      int slot = SLOT_DURATION_US * US;
      int gap = (SLOT_DURATION_US + SLOT_RECOVERY_TIME_US) * US;
      rd_mode = 1'b0;
      lows.delete();
      gaps.delete();
      issue(SWSIG_CMD_WRITE, data);
      wait_idle();
      check_val(8'(lows.size()), 8'h08, "slot count");
      for (int i = 0; i < 8; i++) begin
         if (data[i]) begin
            check_range(lows[i], 1, WRITE_ONE_LOW_LIMIT_US * US - 1, "one low");
         end else begin
            check_range(lows[i], WRITE_ZERO_LOW_FLOOR_US * US, slot, "zero low");
         end
         if (i > 0) begin
            check_range(gaps[i], gap, gap + 4, "slot gap");
         end
      end
      check_val(rx_byte, data, "written byte");
   endtask : run_write

   task automatic run_read(input logic [7:0] data);
      rd_mode = 1'b1;
      tx_byte = data;
      lows.delete();
      issue(SWSIG_CMD_READ, 8'h00);
      wait_idle();
      for (int i = 0; i < 8; i++) check_range(lows[i], READ_INITIATE_LOW_TIME_US * US - 2,
         READ_INITIATE_LOW_TIME_US * US + 2, "read low");
   endtask : run_read

   // Reads fill the buffer with the reader stalled, then it is drained in order.
   task automatic run_fifo();
      i_rd_ready = 1'b0;
      for (int k = 0; k < 8; k++) run_read(8'h3c ^ 8'(k * 37));
      step();
      i_cmd_kind = SWSIG_CMD_READ;
      step();
      check_val({7'h0, o_cmd_ready}, 8'h00, "read while full");
      i_cmd_kind = SWSIG_CMD_WRITE;
      step();
      check_val({7'h0, o_cmd_ready}, 8'h01, "write while full");
      for (int k = 0; k < 8; k++) begin
         check_val({7'h0, o_rd_valid}, 8'h01, "byte waiting");
         check_val(o_rd_data, 8'h3c ^ 8'(k * 37), "read byte");
         i_rd_ready = 1'b1;
         step();
         i_rd_ready = 1'b0;
      end
      check_val({7'h0, o_rd_valid}, 8'h00, "buffer empty");
   endtask : run_fifo

   initial begin
      repeat (2) @(posedge i_clock);
      #1;
      i_sys_rst = 1'b0;
      check_val({7'h0, o_line_oe_n}, 8'h01, "released after reset");
      run_reset(1'b0, 1'b0);
      run_reset(1'b1, 1'b1);
      run_reset(1'b1, 1'b0);
      run_write(8'ha5);
      run_write(8'h80);
      run_fifo();
      complete_run();
   end
endmodule : swsig_master_bench
